/* design/tuning_defs.svh */
// tuning_defs.svh: offsets, field widths, reset values and timing counts
// of the tuning up/down counter; assumes a 100 MHz system clock.
`ifndef TUNING_DEFS_SVH
`define TUNING_DEFS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define CODE_W        19
`define BAND_W        3
`define SB_W          2
`define NUM_BANDS     5
`define NUM_SW        4
`define DIGITS_W      24
`define TMR_W         26

// ----------------------------------------------------------------------
// rates and times, each in its own unit as given
// ----------------------------------------------------------------------
`define CLK_HZ        100000000
`define REF_HZ        5000000
`define STEP_HZ       100
`define FAST_HZ_PER_S 20000
`define SLOW_HZ_PER_S 400
`define DEBOUNCE_US   5000
`define HOLD_MS       500

// ----------------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------------
`define REF_CYC     (`CLK_HZ / `REF_HZ)
`define CMP_DIV     (`REF_HZ / `STEP_HZ)
`define DEBOUNCE_CYC (`DEBOUNCE_US * (`CLK_HZ / 1000000))
`define HOLD_CYC    (`HOLD_MS * (`CLK_HZ / 1000))
`define FAST_CYC    (`CLK_HZ / (`FAST_HZ_PER_S / `STEP_HZ))
`define SLOW_CYC    (`CLK_HZ / (`SLOW_HZ_PER_S / `STEP_HZ))

// ----------------------------------------------------------------------
// band edges in 100 Hz counts, bands 0..4, plain defaults
// ----------------------------------------------------------------------
`define BAND_LO_DEF {19'd280000, 19'd210000, 19'd140000, 19'd70000, 19'd35000}
`define BAND_HI_DEF {19'd297000, 19'd214500, 19'd143500, 19'd73000, 19'd40000}
`define WRAP_SPAN   19'h003E8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BAND    3'h0
`define RST_SB      2'h0

`endif

/* design/tuning_pkg.sv */
// tuning_pkg.sv: types shared by the tuning counter design.
// assumes tuning_defs.svh supplies all numbers.
package tuning_pkg;

  // stepping sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } step_state_t;

endpackage

/* design/tuning_updown_counter.sv */
// tuning_updown_counter.sv: operator tuning switches to synthesizer
// programming code, band-edge handling, references and readout digits.
// assumes switch, band and sideband inputs are raw pins; clk is 100 MHz.
//
// Overview of operation
// - fast switch up raises, down lowers code
// - up past top edge wraps below edge
// - down past bottom holds lowest band count
// - slow switch same behaviour, slower rate
// - fixed hold delay before continuous stepping
// - brief press moves exactly one step
// - step goes up or down, never both
// - counter value is major loop code
// - readout decoder follows major loop code
// - six decimal digits, 100 Hz resolution
// - reference divided to 100 Hz comparison tick
// - frequency set only by divider load
// - minor loop setting from sideband and band
// - both loops timed from one 5 MHz reference
// - fast stepping about 20 kHz per second
// - slow stepping about 400 Hz per second
`include "tuning_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tuning_updown_counter
  import tuning_pkg::*;
#(
  parameter int unsigned               DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int unsigned               HOLD_CYC     = `HOLD_CYC,
  parameter int unsigned               FAST_CYC     = `FAST_CYC,
  parameter int unsigned               SLOW_CYC     = `SLOW_CYC,
  parameter int unsigned               CMP_DIV      = `CMP_DIV,
  parameter logic [5*`CODE_W-1:0]      BAND_LO      = `BAND_LO_DEF,
  parameter logic [5*`CODE_W-1:0]      BAND_HI      = `BAND_HI_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    fast_up,
  input  wire logic                    fast_down,
  input  wire logic                    slow_up,
  input  wire logic                    slow_down,
  input  wire logic [`BAND_W-1:0]      band_sel,
  input  wire logic [`SB_W-1:0]        sideband_sel,
  output logic      [`CODE_W-1:0]      prog_code_q,
  output logic                         prog_load_q,
  output logic      [`BAND_W+`SB_W-1:0] minor_sel_q,
  output logic                         ref_tick_q,
  output logic                         cmp_tick_q,
  output logic      [`DIGITS_W-1:0]    digits_q,
  output logic                         digits_valid_q
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // band edge lookup; out-of-range band codes fall back to band 0
  function automatic logic [`CODE_W-1:0] edge_of(
    input logic [5*`CODE_W-1:0] tbl,
    input logic [`BAND_W-1:0]   b
  );
    logic [`BAND_W-1:0] i;
    i = (b < `BAND_W'(`NUM_BANDS)) ? b : `BAND_W'(0);
    edge_of = tbl[i*`CODE_W +: `CODE_W];
  endfunction

  // one double-dabble step: correct all six digits, then shift in b
  function automatic logic [`DIGITS_W-1:0] dabble(input logic [`DIGITS_W-1:0] v, input logic b);
    logic [`DIGITS_W-1:0] r;
    r = v;
    for (int d = 0; d < 6; d++) begin
      if (r[d*4 +: 4] > 4'h4) begin
        r[d*4 +: 4] = r[d*4 +: 4] + 4'h3;
      end
    end
    dabble = {r[`DIGITS_W-2:0], b};
  endfunction

  // ----------------------------------------------------------------------
  // switch synchronisers and debouncers
  // ----------------------------------------------------------------------
  logic [`NUM_SW-1:0] sw_raw;
  logic [`NUM_SW-1:0] sw_s1_q;
  logic [`NUM_SW-1:0] sw_s2_q;
  logic [`NUM_SW-1:0] sw_db_q;

  assign sw_raw = {slow_down, slow_up, fast_down, fast_up};

  // two flops per pin; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_s1_q <= '0;
      sw_s2_q <= '0;
    end else begin
      sw_s1_q <= sw_raw;
      sw_s2_q <= sw_s1_q;
    end
  end

  // a level is accepted only after it stood unchanged for the full
  // debounce time, so contact bounce never yields a second step
  for (genvar g = 0; g < `NUM_SW; g++) begin : g_db
    logic [`TMR_W-1:0] cnt_q;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q      <= '0;
        sw_db_q[g] <= 1'b0;
      end else if (sw_s2_q[g] == sw_db_q[g]) begin
        cnt_q <= '0;
      end else if (cnt_q >= `TMR_W'(DEBOUNCE_CYC - 1)) begin
        cnt_q      <= '0;
        sw_db_q[g] <= sw_s2_q[g];
      end else begin
        cnt_q <= cnt_q + `TMR_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // band and sideband pins
  // ----------------------------------------------------------------------
  logic [`BAND_W-1:0] band_s1_q;
  logic [`BAND_W-1:0] band_q;
  logic [`BAND_W-1:0] band_prev_q;
  logic [`SB_W-1:0]   sb_s1_q;
  logic [`SB_W-1:0]   sb_q;

  // switch positions settle slowly, so plain double flopping suffices
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      band_s1_q   <= `RST_BAND;
      band_q      <= `RST_BAND;
      band_prev_q <= `RST_BAND;
      sb_s1_q     <= `RST_SB;
      sb_q        <= `RST_SB;
    end else begin
      band_s1_q   <= band_sel;
      band_q      <= band_s1_q;
      band_prev_q <= band_q;
      sb_s1_q     <= sideband_sel;
      sb_q        <= sb_s1_q;
    end
  end

  // minor loop setting picked from band and sideband
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      minor_sel_q <= {`RST_BAND, `RST_SB};
    end else begin
      minor_sel_q <= {band_q, sb_q};
    end
  end

  // ----------------------------------------------------------------------
  // reference and comparison ticks
  // ----------------------------------------------------------------------
  logic [7:0]        ref_cnt_q;
  logic [`TMR_W-1:0] cmp_cnt_q;

  // the 5 MHz reference tick paces both loops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_cnt_q  <= '0;
      ref_tick_q <= 1'b0;
    end else if (ref_cnt_q == 8'(`REF_CYC - 1)) begin
      ref_cnt_q  <= '0;
      ref_tick_q <= 1'b1;
    end else begin
      ref_cnt_q  <= ref_cnt_q + 8'h01;
      ref_tick_q <= 1'b0;
    end
  end

  // fixed division of the reference sets the 100 Hz step size
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_cnt_q  <= '0;
      cmp_tick_q <= 1'b0;
    end else begin
      cmp_tick_q <= 1'b0;
      if (ref_tick_q) begin
        if (cmp_cnt_q >= `TMR_W'(CMP_DIV - 1)) begin
          cmp_cnt_q  <= '0;
          cmp_tick_q <= 1'b1;
        end else begin
          cmp_cnt_q <= cmp_cnt_q + `TMR_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // stepping sequencer
  // ----------------------------------------------------------------------
  logic        want_up;
  logic        want_dn;
  logic        fast_held;
  step_state_t state_q;
  logic [`TMR_W-1:0] tmr_q;
  logic        dir_up_q;
  logic        step_up_q;
  logic        step_dn_q;

  // both directions at once is treated as no request
  assign want_up   = (sw_db_q[0] | sw_db_q[2]) & ~(sw_db_q[1] | sw_db_q[3]);
  assign want_dn   = (sw_db_q[1] | sw_db_q[3]) & ~(sw_db_q[0] | sw_db_q[2]);
  assign fast_held = sw_db_q[0] | sw_db_q[1];

  // a press steps once at once, then waits out the hold delay; only a
  // switch still held after it gets continuous stepping at its rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      tmr_q     <= '0;
      dir_up_q  <= 1'b0;
      step_up_q <= 1'b0;
      step_dn_q <= 1'b0;
    end else begin
      step_up_q <= 1'b0;
      step_dn_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          tmr_q <= '0;
          if (want_up || want_dn) begin
            dir_up_q  <= want_up;
            step_up_q <= want_up;
            step_dn_q <= want_dn;
            state_q   <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (dir_up_q ? !want_up : !want_dn) begin
            state_q <= ST_IDLE;
          end else if (tmr_q >= `TMR_W'(HOLD_CYC - 1)) begin
            tmr_q   <= '0;
            state_q <= ST_RUN;
          end else begin
            tmr_q <= tmr_q + `TMR_W'(1);
          end
        end
        ST_RUN: begin
          if (dir_up_q ? !want_up : !want_dn) begin
            state_q <= ST_IDLE;
          end else if (tmr_q >= `TMR_W'((fast_held ? FAST_CYC : SLOW_CYC) - 1)) begin
            tmr_q     <= '0;
            step_up_q <= dir_up_q;
            step_dn_q <= !dir_up_q;
          end else begin
            tmr_q <= tmr_q + `TMR_W'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // up/down counter and divider load
  // ----------------------------------------------------------------------
  logic [`CODE_W-1:0] lo_edge;
  logic [`CODE_W-1:0] hi_edge;

  assign lo_edge = edge_of(BAND_LO, band_q);
  assign hi_edge = edge_of(BAND_HI, band_q);

  // a band change restarts at the bottom of the new band; the count is
  // the divider ratio itself, one count per 100 Hz
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_code_q <= BAND_LO[`CODE_W-1:0];
      prog_load_q <= 1'b0;
    end else if (band_q != band_prev_q) begin
      prog_code_q <= lo_edge;
      prog_load_q <= 1'b1;
    end else if (step_up_q) begin
      prog_load_q <= 1'b1;
      if (prog_code_q >= hi_edge) begin
        prog_code_q <= hi_edge - `WRAP_SPAN;
      end else begin
        prog_code_q <= prog_code_q + `CODE_W'(1);
      end
    end else if (step_dn_q) begin
      prog_load_q <= 1'b1;
      if (prog_code_q <= lo_edge) begin
        prog_code_q <= lo_edge;
      end else begin
        prog_code_q <= prog_code_q - `CODE_W'(1);
      end
    end else begin
      prog_load_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // readout decoder
  // ----------------------------------------------------------------------
  logic [`CODE_W-1:0]   bin_q;
  logic [`DIGITS_W-1:0] bcd_q;
  logic [4:0]           bit_cnt_q;
  logic                 busy_q;

  // each load restarts the conversion; loads are far slower than the
  // nineteen cycles a conversion needs, so digits never lag long
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bin_q          <= BAND_LO[`CODE_W-1:0]; // converts the reset code first
      bcd_q          <= '0;
      bit_cnt_q      <= '0;
      busy_q         <= 1'b1;
      digits_q       <= '0;
      digits_valid_q <= 1'b0;
    end else if (prog_load_q) begin
      bin_q          <= prog_code_q;
      bcd_q          <= '0;
      bit_cnt_q      <= '0;
      busy_q         <= 1'b1;
      digits_valid_q <= 1'b0;
    end else if (busy_q) begin
      bcd_q     <= dabble(bcd_q, bin_q[`CODE_W-1]);
      bin_q     <= {bin_q[`CODE_W-2:0], 1'b0};
      bit_cnt_q <= bit_cnt_q + 5'h01;
      if (bit_cnt_q == 5'(`CODE_W - 1)) begin
        busy_q <= 1'b0;
      end
    end else if (!digits_valid_q) begin
      digits_q       <= bcd_q;
      digits_valid_q <= 1'b1;
    end
  end

endmodule // tuning_updown_counter

`default_nettype wire

/* bench/tuning_monitor.sv */
// tuning_monitor.sv: port assertions for the tuning up/down counter.
// assumes tuning_defs.svh on the include path; bound from the testbench.
`include "tuning_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tuning_monitor #(
  parameter int unsigned CMP_DIV = 5
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic [`BAND_W-1:0]       band_sel,
  input wire logic [`SB_W-1:0]         sideband_sel,
  input wire logic [`CODE_W-1:0]       prog_code_q,
  input wire logic                     prog_load_q,
  input wire logic [`BAND_W+`SB_W-1:0] minor_sel_q,
  input wire logic                     ref_tick_q,
  input wire logic                     cmp_tick_q,
  input wire logic [`DIGITS_W-1:0]     digits_q,
  input wire logic                     digits_valid_q
);
  // one comparison tick spans CMP_DIV reference ticks of 20 cycles
  localparam int CMP_GAP = CMP_DIV * 20;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_ref_period: assert property (ref_tick_q |-> ##20 ref_tick_q)
    else $error("reference tick period wrong");
  a_ref_gap_quiet: assert property (ref_tick_q |=> !ref_tick_q [*8])
    else $error("reference tick too close");
  a_cmp_follows_ref: assert property (cmp_tick_q |-> $past(ref_tick_q))
    else $error("comparison tick not after reference tick");
  a_cmp_period: assert property (cmp_tick_q |-> ##CMP_GAP cmp_tick_q)
    else $error("comparison tick period wrong");
  a_load_on_change: assert property ($changed(prog_code_q) |-> prog_load_q)
    else $error("code changed without load strobe");
  a_up_single_step: assert property ((prog_code_q > $past(prog_code_q))
    && (prog_code_q - $past(prog_code_q) < 19'd1000)
    |-> prog_code_q == $past(prog_code_q) + 19'd1) else $error("up step not one count");
  a_down_single_step: assert property ((prog_code_q < $past(prog_code_q))
    && ($past(prog_code_q) - prog_code_q < 19'd1000)
    |-> prog_code_q == $past(prog_code_q) - 19'd1) else $error("down step not one count");
  a_digits_clear: assert property (prog_load_q |=> !digits_valid_q)
    else $error("readout still valid after load");
  a_digits_hold: assert property (digits_valid_q && $past(digits_valid_q) |-> $stable(digits_q))
    else $error("readout moved while valid");
  a_minor_track: assert property (({band_sel, sideband_sel}
    == $past({band_sel, sideband_sel})) [*5] |-> minor_sel_q == {band_sel, sideband_sel})
    else $error("minor loop select not following selectors");

  // main scenarios reached
  c_wrap: cover property (prog_load_q && $past(prog_code_q) - prog_code_q == 19'd1000);
  c_floor: cover property (prog_load_q && $stable(prog_code_q));
  c_valid: cover property ($rose(digits_valid_q));
endmodule // tuning_monitor
`default_nettype wire

/* bench/tuning_panel.sv */
// tuning_panel.sv: operator switch panel and programmable divider model.
// assumes the testbench calls its tasks; drives at the falling edge.
`include "tuning_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tuning_panel (
  input  wire logic                clk,
  input  wire logic [`CODE_W-1:0]  prog_code_q,
  input  wire logic                prog_load_q,
  output logic                     fast_up,
  output logic                     fast_down,
  output logic                     slow_up,
  output logic                     slow_down,
  output logic [`BAND_W-1:0]       band_sel,
  output logic [`SB_W-1:0]         sideband_sel,
  output logic [`CODE_W-1:0]       ratio_q
);
  // switches at rest, band 0 at power-up
  initial begin
    {slow_down, slow_up, fast_down, fast_up} = 4'h0;
    band_sel = 3'h0;
    sideband_sel = 2'h0;
  end

  // divider only takes a ratio on the strobe, never by sampling the bus
  always @(posedge clk) begin
    if (prog_load_q) ratio_q <= prog_code_q;
  end

  task automatic set_sw(input logic [3:0] s);
    @(negedge clk);
    {slow_down, slow_up, fast_down, fast_up} = s;
  endtask

  task automatic set_band(input logic [2:0] b, input logic [1:0] sb);
    @(negedge clk);
    band_sel = b;
    sideband_sel = sb;
  endtask
endmodule // tuning_panel
`default_nettype wire

/* bench/testbench.sv */
// testbench.sv: directed scenarios for the tuning up/down counter.
// assumes short sim counts; band edges keep their plain defaults.
`include "tuning_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
  localparam int HOLD = 50;
  localparam int FAST = 5;
  localparam int SLOW = 40;
  localparam int CMP_DIV = 5;
  logic clk, rst_n, fast_up, fast_down, slow_up, slow_down, prog_load_q;
  logic ref_tick_q, cmp_tick_q, digits_valid_q;
  logic [`BAND_W-1:0]       band_sel;
  logic [`SB_W-1:0]         sideband_sel;
  logic [`CODE_W-1:0]       prog_code_q, ratio_q;
  logic [`BAND_W+`SB_W-1:0] minor_sel_q;
  logic [`DIGITS_W-1:0]     digits_q;
  int                       bad_count, num_checks;

  tuning_updown_counter #(.DEBOUNCE_CYC(4), .HOLD_CYC(HOLD), .FAST_CYC(FAST),
    .SLOW_CYC(SLOW), .CMP_DIV(CMP_DIV))
  i_tuning_updown_counter (.clk(clk), .rst_n(rst_n), .fast_up(fast_up),
    .fast_down(fast_down), .slow_up(slow_up), .slow_down(slow_down),
    .band_sel(band_sel), .sideband_sel(sideband_sel), .prog_code_q(prog_code_q),
    .prog_load_q(prog_load_q), .minor_sel_q(minor_sel_q), .ref_tick_q(ref_tick_q),
    .cmp_tick_q(cmp_tick_q), .digits_q(digits_q), .digits_valid_q(digits_valid_q));

  tuning_panel i_tuning_panel (.clk(clk), .prog_code_q(prog_code_q),
    .prog_load_q(prog_load_q), .fast_up(fast_up), .fast_down(fast_down),
    .slow_up(slow_up), .slow_down(slow_down), .band_sel(band_sel),
    .sideband_sel(sideband_sel), .ratio_q(ratio_q));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  // sample 1 ns after the edge so the edge's updates have landed
  task automatic wait_load(output int n);
    n = 0;
    do begin @(posedge clk); #1; n++; end
    while (prog_load_q !== 1'b1 && n < 3000);
    `CHK(prog_load_q, 1'b1)
  endtask

  task automatic count_loads(input int c, output int k);
    k = 0;
    repeat (c) begin @(posedge clk); #1; if (prog_load_q === 1'b1) k++; end
  endtask

  // press under the hold delay, then release and let it settle
  task automatic tap(input logic [3:0] s, output int k);
    int k1, k2;
    i_tuning_panel.set_sw(s);
    count_loads(14, k1);
    i_tuning_panel.set_sw(4'h0);
    count_loads(70, k2);
    k = k1 + k2;
  endtask

  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_single;
    int k;
    tap(4'h1, k);
    `CHK(k, 1)
    `CHK(prog_code_q, 19'd35001)
    `CHK(ratio_q, 19'd35001)
    `CHK(digits_valid_q, 1'b1)
    `CHK(digits_q, 24'h035001)
  endtask

  task automatic t_floor;
    int k, k2;
    tap(4'h8, k);
    `CHK(prog_code_q, 19'd35000)
    i_tuning_panel.set_sw(4'h2);
    count_loads(200, k);
    i_tuning_panel.set_sw(4'h0);
    count_loads(30, k2);
    `CHK(prog_code_q, 19'd35000)
    `CHK(k > 2, 1'b1)
  endtask

  // up and down together must not step either way
  task automatic t_both;
    int k;
    i_tuning_panel.set_sw(4'h3);
    count_loads(200, k);
    i_tuning_panel.set_sw(4'h0);
    `CHK(k, 0)
    count_loads(30, k);
    // a one-cycle glitch is shorter than the debounce time
    i_tuning_panel.set_sw(4'h1);
    i_tuning_panel.set_sw(4'h0);
    count_loads(30, k);
    `CHK(k, 0)
  endtask

  task automatic t_fast;
    int g, i;
    logic [`CODE_W-1:0] prev;
    i_tuning_panel.set_sw(4'h1);
    wait_load(g);
    wait_load(g);
    `CHK(g >= HOLD - 2, 1'b1)
    wait_load(g);
    `CHK(g, FAST)
    i = 0;
    do begin prev = prog_code_q; wait_load(g); i++; end
    while (prog_code_q > prev && i < 6000);
    `CHK(prev, 19'd40000)
    `CHK(prog_code_q, 19'd39000)
    i_tuning_panel.set_sw(4'h0);
    count_loads(30, g);
  endtask

  task automatic t_slow;
    int g;
    logic [`CODE_W-1:0] prev;
    i_tuning_panel.set_sw(4'h4);
    wait_load(g);
    wait_load(g);
    prev = prog_code_q;
    wait_load(g);
    `CHK(g, SLOW)
    `CHK(prog_code_q, prev + 19'd1)
    i_tuning_panel.set_sw(4'h0);
    count_loads(30, g);
  endtask

  task automatic t_band;
    int g;
    i_tuning_panel.set_band(3'h1, 2'h2);
    wait_load(g);
    `CHK(prog_code_q, 19'd70000)
    count_loads(6, g);
    `CHK(minor_sel_q, 5'h06)
    // an unused band code falls back to the first band
    i_tuning_panel.set_band(3'h5, 2'h1);
    wait_load(g);
    `CHK(prog_code_q, 19'd35000)
    i_tuning_panel.set_band(3'h0, 2'h1);
    wait_load(g);
    `CHK(prog_code_q, 19'd35000)
  endtask

  // ----------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (40) @(posedge clk);
    #1;
    `CHK(prog_code_q, 19'd35000)
    `CHK(digits_valid_q, 1'b1)
    `CHK(digits_q, 24'h035000)
    t_single();
    t_floor();
    t_both();
    t_fast();
    t_slow();
    t_band();
    stop_test();
  end

  // whole run is near 26000 cycles, mostly the climb to the wrap; 50000 means a hang
  initial begin
    #500000;
    bad_count++;
    stop_test();
  end
endmodule // testbench

bind tuning_updown_counter tuning_monitor #(.CMP_DIV(CMP_DIV)) i_tuning_monitor (
  .clk(clk), .rst_n(rst_n), .band_sel(band_sel), .sideband_sel(sideband_sel),
  .prog_code_q(prog_code_q), .prog_load_q(prog_load_q), .minor_sel_q(minor_sel_q),
  .ref_tick_q(ref_tick_q), .cmp_tick_q(cmp_tick_q), .digits_q(digits_q),
  .digits_valid_q(digits_valid_q));
`default_nettype wire
